// ===== core/ahm_consts.svh
`ifndef AHM_CONSTS_SVH
`define AHM_CONSTS_SVH

// Register byte offsets
`define AHM_REG_CONFIG     8'h00
`define AHM_REG_FL_MASK    8'h04
`define AHM_REG_FL_BASE    8'h08
`define AHM_REG_SL_BASE    8'h0C
`define AHM_REG_HDR_MASK   8'h10
`define AHM_REG_LKUP_ADDR  8'h14
`define AHM_REG_INT_CT     8'h18
`define AHM_REG_EXT_CT     8'h1C
`define AHM_REG_MATCH_BASE 8'h20
`define AHM_REG_MATCH_END  8'h24
`define AHM_REG_POINT_BASE 8'h28
`define AHM_REG_STATUS     8'h2C
`define AHM_REG_PHY_MATCH  8'h30
`define AHM_REG_PHY_POINT  8'h34

// Configuration field positions
`define AHM_CFG_EXT        0
`define AHM_CFG_ACP        1
`define AHM_CFG_MPHY       2
`define AHM_CFG_NPHY_LO    4

// First-level mask field positions and header layout
`define AHM_FL_CHECK_BIT   0
`define AHM_FL_OAM_BIT     3
`define AHM_FL_FIELDS      32'hFFF0_000E
`define AHM_VCI_LO         4

// Table geometry
`define AHM_INT_CHAN_MAX   16'h001F
`define AHM_PHY_MATCH_STEP 16'h0020
`define AHM_PHY_POINT_STEP 16'h0010

// Reset values
`define AHM_RST_WORD       32'h0000_0000

`endif

// ===== core/ahm_pkg.sv
package ahm_pkg;

    // Lookup sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE = 6'b00_0001,
        ST_FL_RD = 6'b00_0010,
        ST_SL_RD = 6'b00_0100,
        ST_CAM_WR = 6'b00_1000,
        ST_CAM_RD = 6'b01_0000,
        ST_DONE = 6'b10_0000
    } ahm_state_t;

    // Link handshake states, one-hot
    typedef enum logic [4:0] {
        LK_IDLE = 5'b0_0001,
        LK_RX_SEL = 5'b0_0010,
        LK_RX = 5'b0_0100,
        LK_TX_SEL = 5'b0_1000,
        LK_TX = 5'b1_0000
    } ahm_link_t;

    // Memory bus request
    typedef struct packed {
        logic req;
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } ahm_mem_t;

    // Mapping result
    typedef struct packed {
        logic raw;
        logic [1:0] phy;
        logic [15:0] chan;
        logic [31:0] conn_addr;
    } ahm_result_t;

endpackage : ahm_pkg

// ===== core/ahm_map.sv
// How it works
// - Extended and compression select both set choose two-level address compression.
// - GFC, VPI, PTI masked by first mask give pointer1; fetch base plus pointer1 times 4.
// - First-level entry holds 16-bit VCI mask and 16-bit second table offset.
// - Zero first-level entry sends the cell to the raw cell queue.
// - VCI masked by second mask gives pointer2; read base plus offset plus pointer2 times 2.
// - Second-level entry is the channel number, 0 to 65535.
// - With check flag set, any nonzero unmasked header bit other than CLP (bit 0) sends cell raw.
// - First mask lacking PTI top bit plus header PTI top bit set means raw.
// - Channel 0 is raw queue at internal base; 1 to 31 at channel times 64 there.
// - Channels above 31 sit at channel times 64 plus external base.
// - Extended set with compression clear selects external lookup memory mapping.
// - Masked header is written to lookup address, then read back from same address.
// - Read data bit D0 low flags a match, D16-31 the channel; else raw.
// - Up to four PHYs, addressed through four extra port pins.
// - In multi-PHY mode the two low channel bits carry the PHY number.
// - Receive PHY address is read from request lines, put on select before enable.
// - Per-PHY match base and end step by N*32, pointing base by N*16.
// - Multi-PHY compression appends the 2-bit PHY as pointer1 low bits.
// - Lookup address has low 4 bits clear; PHY goes on address bits 0-1.
// - Transmit PHY number is put on select lines before transmit enable.
`include "ahm_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module ahm_map (
    input wire logic mclk, // 200 MHz clock
    input wire logic rst_n, // Synchronous reset
    input wire logic [7:0] reg_addr, // Register byte address
    input wire logic [31:0] reg_wdata, // Register write data
    input wire logic reg_we, // Register write strobe
    input wire logic reg_re, // Register read strobe
    output logic [31:0] reg_rdata, // Read data, cycle after strobe
    input wire logic hdr_valid, // Received header present
    input wire logic [31:0] hdr_word, // GFC VPI VCI PTI CLP
    output logic hdr_ready, // Header can be taken
    output ahm_pkg::ahm_result_t res, // Mapping result
    output logic res_valid, // Result pulse
    output ahm_pkg::ahm_mem_t mem, // System bus request
    input wire logic mem_ack, // Bus transfer done pulse
    input wire logic [31:0] mem_rdata, // Bus read data, D0 is bit 31
    input wire logic [1:0] phy_request_lines, // PHY address pins
    input wire logic rx_cell_avail, // Receive cell available pin
    input wire logic tx_cell_avail, // Transmit space available pin
    output logic [1:0] phy_select_lines, // PHY select pins
    output logic rx_enable_n, // Receive enable pin
    output logic tx_enable_n, // Transmit enable pin
    input wire logic tx_req, // Transmit queue entry ready
    input wire logic [15:0] tx_chan, // Transmit queue entry
    input wire logic tx_done // Transmit cell finished
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Gathers the bits of v under set bits of m, lowest first
    function automatic logic [15:0] gather(input logic [31:0] v, input logic [31:0] m);
        logic [15:0] r;
        int unsigned k;
        r = 16'h0000;
        k = 0;
        for (int i = 0; i < 32; i++) begin
            if (m[i]) begin
                if (k < 16) begin
                    r[k[3:0]] = v[i];
                end
                k++;
            end
        end
        return r;
    endfunction : gather

    // Connection entry address of a channel
    function automatic logic [31:0] conn_of(input logic [15:0] ch, input logic [31:0] ib,
                                            input logic [31:0] eb);
        logic [31:0] off;
        off = {10'h000, ch, 6'h00};
        return (ch > `AHM_INT_CHAN_MAX) ? eb + off : ib + off;
    endfunction : conn_of

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0] cfg_q, fl_mask_q, fl_base_q, sl_base_q, hdr_mask_q, lkup_q;
    logic [31:0] int_ct_q, ext_ct_q;
    logic [15:0] m_base_q, m_end_q, p_base_q;
    logic [31:0] rdata_d;

    wire logic ext_sel = cfg_q[`AHM_CFG_EXT];
    wire logic acp_sel = cfg_q[`AHM_CFG_ACP];
    wire logic mphy = cfg_q[`AHM_CFG_MPHY];
    wire logic [1:0] nphy = cfg_q[`AHM_CFG_NPHY_LO +: 2];

    // Register writes
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cfg_q <= `AHM_RST_WORD;
            fl_mask_q <= `AHM_RST_WORD;
            fl_base_q <= `AHM_RST_WORD;
            sl_base_q <= `AHM_RST_WORD;
            hdr_mask_q <= `AHM_RST_WORD;
            lkup_q <= `AHM_RST_WORD;
            int_ct_q <= `AHM_RST_WORD;
            ext_ct_q <= `AHM_RST_WORD;
            m_base_q <= 16'h0000;
            m_end_q <= 16'h0000;
            p_base_q <= 16'h0000;
        end else if (reg_we) begin
            case (reg_addr)
                `AHM_REG_CONFIG: cfg_q <= {26'h000_0000, reg_wdata[5:4], 1'b0, reg_wdata[2:0]};
                `AHM_REG_FL_MASK: fl_mask_q <= reg_wdata;
                `AHM_REG_FL_BASE: fl_base_q <= reg_wdata;
                `AHM_REG_SL_BASE: sl_base_q <= reg_wdata;
                `AHM_REG_HDR_MASK: hdr_mask_q <= reg_wdata;
                `AHM_REG_LKUP_ADDR: lkup_q <= reg_wdata;
                `AHM_REG_INT_CT: int_ct_q <= reg_wdata;
                `AHM_REG_EXT_CT: ext_ct_q <= reg_wdata;
                `AHM_REG_MATCH_BASE: m_base_q <= reg_wdata[15:0];
                `AHM_REG_MATCH_END: m_end_q <= reg_wdata[15:0];
                `AHM_REG_POINT_BASE: p_base_q <= reg_wdata[15:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers: three flops, filtered on agreement
    // ------------------------------------------------------------
    logic [3:0] s1_q, s2_q, s3_q, pin_q;
    wire logic [3:0] pin_raw = {tx_cell_avail, rx_cell_avail, phy_request_lines};

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s1_q <= 4'h0;
            s2_q <= 4'h0;
            s3_q <= 4'h0;
            pin_q <= 4'h0;
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_q <= (s2_q == s3_q) ? s3_q : pin_q;
        end
    end

    wire logic [1:0] req_phy = pin_q[1:0];
    wire logic rx_cav = pin_q[2];
    wire logic tx_cav = pin_q[3];

    // ------------------------------------------------------------
    // PHY link handshake
    // ------------------------------------------------------------
    ahm_pkg::ahm_link_t lk_q, lk_d;
    logic [1:0] sel_q, cur_phy_q;
    logic tx_pend_q;
    logic [1:0] tx_phy_q;
    logic hdr_take;

    wire logic phy_ok = !mphy || (req_phy <= nphy);
    wire logic rx_go = rx_cav && phy_ok;
    wire logic tx_fin = (lk_q == ahm_pkg::LK_TX) && tx_done;

    // Next link state: receive wins over transmit
    always_comb begin
        lk_d = lk_q;
        case (lk_q)
            ahm_pkg::LK_IDLE: begin
                if (rx_go) begin
                    lk_d = ahm_pkg::LK_RX_SEL;
                end else if (tx_pend_q && tx_cav) begin
                    lk_d = ahm_pkg::LK_TX_SEL;
                end
            end
            ahm_pkg::LK_RX_SEL: lk_d = ahm_pkg::LK_RX;
            ahm_pkg::LK_RX: lk_d = hdr_take ? ahm_pkg::LK_IDLE : ahm_pkg::LK_RX;
            ahm_pkg::LK_TX_SEL: lk_d = ahm_pkg::LK_TX;
            ahm_pkg::LK_TX: lk_d = tx_done ? ahm_pkg::LK_IDLE : ahm_pkg::LK_TX;
            default: lk_d = ahm_pkg::LK_IDLE;
        endcase
    end

    // Select is loaded a cycle before the matching enable
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            lk_q <= ahm_pkg::LK_IDLE;
            sel_q <= 2'b00;
            cur_phy_q <= 2'b00;
            tx_pend_q <= 1'b0;
            tx_phy_q <= 2'b00;
        end else begin
            lk_q <= lk_d;
            if (lk_q == ahm_pkg::LK_IDLE && rx_go) begin
                sel_q <= mphy ? req_phy : 2'b00;
                cur_phy_q <= mphy ? req_phy : 2'b00;
            end else if (lk_q == ahm_pkg::LK_IDLE && tx_pend_q && tx_cav) begin
                sel_q <= mphy ? tx_phy_q : 2'b00;
            end
            // A new entry in the finishing cycle wins over the clear
            if (tx_req && (!tx_pend_q || tx_fin)) begin
                tx_pend_q <= 1'b1;
                tx_phy_q <= tx_chan[1:0];
            end else if (tx_fin) begin
                tx_pend_q <= 1'b0;
            end
        end
    end

    // Enables follow the select state
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rx_enable_n <= 1'b1;
            tx_enable_n <= 1'b1;
        end else begin
            rx_enable_n <= !(lk_d == ahm_pkg::LK_RX);
            tx_enable_n <= !(lk_d == ahm_pkg::LK_TX);
        end
    end

    assign phy_select_lines = sel_q;

    // ------------------------------------------------------------
    // Header decode
    // ------------------------------------------------------------
    logic [31:0] hdr_q;
    logic [1:0] phy_q;
    logic [15:0] sl_mask_q, sl_off_q;
    ahm_pkg::ahm_state_t st_q, st_d;

    wire logic [31:0] fl_fields = fl_mask_q & `AHM_FL_FIELDS;
    // A header taken this cycle is looked up before it lands in hdr_q
    wire logic [31:0] hdr_src = hdr_take ? hdr_word : hdr_q;
    wire logic [1:0] phy_src = hdr_take ? cur_phy_q : phy_q;
    wire logic [15:0] ptr1 = gather(hdr_src, fl_fields);
    wire logic [17:0] ptr1_x = mphy ? {ptr1, phy_src} : {2'b00, ptr1};
    wire logic [31:0] fl_addr = fl_base_q + {12'h000, ptr1_x, 2'b00};
    wire logic [15:0] vci = hdr_q[`AHM_VCI_LO +: 16];
    // The second-level request is formed from the first-level word as it arrives
    wire logic fl_hit = (st_q == ahm_pkg::ST_FL_RD);
    wire logic [15:0] sl_mask_src = fl_hit ? mem_rdata[31:16] : sl_mask_q;
    wire logic [15:0] sl_off_src = fl_hit ? mem_rdata[15:0] : sl_off_q;
    wire logic [15:0] ptr2 = gather({16'h0000, vci}, {16'h0000, sl_mask_src});
    wire logic [31:0] sl_addr = sl_base_q + {16'h0000, sl_off_src} + {15'h0000, ptr2, 1'b0};
    wire logic [31:0] keep = fl_fields | {12'h000, sl_mask_q, 4'h0};
    wire logic bad_unused = fl_mask_q[`AHM_FL_CHECK_BIT] && |(hdr_q[31:1] & ~keep[31:1]);
    wire logic oam = !fl_mask_q[`AHM_FL_OAM_BIT] && hdr_q[`AHM_FL_OAM_BIT];
    wire logic [31:0] cam_addr = mphy ? {lkup_q[31:4], 2'b00, phy_src} : lkup_q;
    wire logic [15:0] sl_word = mem.addr[1] ? mem_rdata[15:0] : mem_rdata[31:16];
    wire logic cam_miss = mem_rdata[31];

    assign hdr_take = hdr_valid && hdr_ready;

    // ------------------------------------------------------------
    // Lookup sequencer
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        case (st_q)
            ahm_pkg::ST_IDLE: begin
                if (hdr_take && ext_sel) begin
                    st_d = acp_sel ? ahm_pkg::ST_FL_RD : ahm_pkg::ST_CAM_WR;
                end else if (hdr_take) begin
                    st_d = ahm_pkg::ST_DONE;
                end
            end
            ahm_pkg::ST_FL_RD: begin
                if (mem_ack) begin
                    st_d = (mem_rdata == 32'h0000_0000) ? ahm_pkg::ST_DONE : ahm_pkg::ST_SL_RD;
                end
            end
            ahm_pkg::ST_SL_RD: st_d = mem_ack ? ahm_pkg::ST_DONE : ahm_pkg::ST_SL_RD;
            ahm_pkg::ST_CAM_WR: st_d = mem_ack ? ahm_pkg::ST_CAM_RD : ahm_pkg::ST_CAM_WR;
            ahm_pkg::ST_CAM_RD: st_d = mem_ack ? ahm_pkg::ST_DONE : ahm_pkg::ST_CAM_RD;
            ahm_pkg::ST_DONE: st_d = ahm_pkg::ST_IDLE;
            default: st_d = ahm_pkg::ST_IDLE;
        endcase
    end

    logic raw_q;
    logic [15:0] chan_q;

    // State, table words and bus request
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_q <= ahm_pkg::ST_IDLE;
            hdr_q <= `AHM_RST_WORD;
            phy_q <= 2'b00;
            sl_mask_q <= 16'h0000;
            sl_off_q <= 16'h0000;
            raw_q <= 1'b0;
            chan_q <= 16'h0000;
            mem <= '0;
        end else begin
            st_q <= st_d;
            if (hdr_take) begin
                hdr_q <= hdr_word;
                phy_q <= cur_phy_q;
                raw_q <= !ext_sel;
                chan_q <= 16'h0000;
            end
            case (st_q)
                ahm_pkg::ST_FL_RD: if (mem_ack) begin
                    sl_mask_q <= mem_rdata[31:16];
                    sl_off_q <= mem_rdata[15:0];
                    raw_q <= (mem_rdata == 32'h0000_0000) || oam;
                end
                ahm_pkg::ST_SL_RD: if (mem_ack) begin
                    chan_q <= sl_word;
                    raw_q <= raw_q || bad_unused;
                end
                ahm_pkg::ST_CAM_RD: if (mem_ack) begin
                    chan_q <= mem_rdata[15:0];
                    raw_q <= cam_miss;
                end
                default: ;
            endcase
            // Bus request for the state being entered
            if (st_d == ahm_pkg::ST_FL_RD && st_q != ahm_pkg::ST_FL_RD) begin
                mem <= '{req: 1'b1, we: 1'b0, addr: fl_addr, wdata: `AHM_RST_WORD};
            end else if (st_d == ahm_pkg::ST_SL_RD && st_q != ahm_pkg::ST_SL_RD) begin
                mem <= '{req: 1'b1, we: 1'b0, addr: sl_addr, wdata: `AHM_RST_WORD};
            end else if (st_d == ahm_pkg::ST_CAM_WR && st_q != ahm_pkg::ST_CAM_WR) begin
                mem <= '{req: 1'b1, we: 1'b1, addr: cam_addr,
                         wdata: hdr_word & hdr_mask_q};
            end else if (st_d == ahm_pkg::ST_CAM_RD && st_q != ahm_pkg::ST_CAM_RD) begin
                mem <= '{req: 1'b1, we: 1'b0, addr: mem.addr, wdata: `AHM_RST_WORD};
            end else if (mem_ack) begin
                mem.req <= 1'b0;
                mem.we <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Result and ready
    // ------------------------------------------------------------
    wire logic [15:0] fin_chan = raw_q ? 16'h0000 : chan_q;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            res <= '0;
            res_valid <= 1'b0;
            hdr_ready <= 1'b0;
        end else begin
            res_valid <= (st_q == ahm_pkg::ST_DONE);
            hdr_ready <= (st_d == ahm_pkg::ST_IDLE) && (lk_d == ahm_pkg::LK_RX) && !hdr_take;
            if (st_q == ahm_pkg::ST_DONE) begin
                res.raw <= raw_q;
                res.chan <= fin_chan;
                res.phy <= mphy ? fin_chan[1:0] : 2'b00;
                res.conn_addr <= conn_of(fin_chan, int_ct_q, ext_ct_q);
            end
        end
    end

    // ------------------------------------------------------------
    // Register reads, with per-PHY table views
    // ------------------------------------------------------------
    wire logic [15:0] phy_n = {14'h0000, cur_phy_q};
    wire logic [15:0] m_base_n = m_base_q + 16'(phy_n * `AHM_PHY_MATCH_STEP);
    wire logic [15:0] m_end_n = m_end_q + 16'(phy_n * `AHM_PHY_MATCH_STEP);
    wire logic [15:0] p_base_n = p_base_q + 16'(phy_n * `AHM_PHY_POINT_STEP);
    wire logic [31:0] status_w = {chan_q, 8'h00, 2'b00, cur_phy_q, 2'b00, raw_q,
                                  st_q != ahm_pkg::ST_IDLE};

    always_comb begin
        case (reg_addr)
            `AHM_REG_CONFIG: rdata_d = cfg_q;
            `AHM_REG_FL_MASK: rdata_d = fl_mask_q;
            `AHM_REG_FL_BASE: rdata_d = fl_base_q;
            `AHM_REG_SL_BASE: rdata_d = sl_base_q;
            `AHM_REG_HDR_MASK: rdata_d = hdr_mask_q;
            `AHM_REG_LKUP_ADDR: rdata_d = lkup_q;
            `AHM_REG_INT_CT: rdata_d = int_ct_q;
            `AHM_REG_EXT_CT: rdata_d = ext_ct_q;
            `AHM_REG_MATCH_BASE: rdata_d = {16'h0000, m_base_q};
            `AHM_REG_MATCH_END: rdata_d = {16'h0000, m_end_q};
            `AHM_REG_POINT_BASE: rdata_d = {16'h0000, p_base_q};
            `AHM_REG_STATUS: rdata_d = status_w;
            `AHM_REG_PHY_MATCH: rdata_d = {m_end_n, m_base_n};
            `AHM_REG_PHY_POINT: rdata_d = {16'h0000, p_base_n};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= reg_re ? rdata_d : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_mode_comp;
        @(posedge mclk) disable iff (!rst_n)
        (hdr_take && ext_sel && acp_sel) |=> (st_q == ahm_pkg::ST_FL_RD) && mem.req && !mem.we;
    endproperty
    a_mode_comp: assert property (p_mode_comp) else $error("compression not started");

    property p_mode_cam;
        @(posedge mclk) disable iff (!rst_n)
        (hdr_take && ext_sel && !acp_sel) |=> (st_q == ahm_pkg::ST_CAM_WR) && mem.we;
    endproperty
    a_mode_cam: assert property (p_mode_cam) else $error("lookup memory write not started");

    property p_cam_readback;
        @(posedge mclk) disable iff (!rst_n)
        (st_q == ahm_pkg::ST_CAM_WR && mem_ack) |=> mem.req && !mem.we && $stable(mem.addr);
    endproperty
    a_cam_readback: assert property (p_cam_readback) else $error("readback address moved");

    property p_cam_miss;
        @(posedge mclk) disable iff (!rst_n)
        (st_q == ahm_pkg::ST_CAM_RD && mem_ack && mem_rdata[31]) |=> ##1 res_valid && res.raw
            && res.chan == 16'h0000;
    endproperty
    a_cam_miss: assert property (p_cam_miss) else $error("unmatched cell not raw");

    property p_fl_null;
        @(posedge mclk) disable iff (!rst_n)
        (st_q == ahm_pkg::ST_FL_RD && mem_ack && mem_rdata == 32'h0000_0000) |=> ##1 res_valid
            && res.raw;
    endproperty
    a_fl_null: assert property (p_fl_null) else $error("null entry not raw");

    property p_ext_conn;
        @(posedge mclk) disable iff (!rst_n)
        (res_valid && res.chan > 16'h001F) |-> res.conn_addr == ext_ct_q + {10'h000, res.chan, 6'h00};
    endproperty
    a_ext_conn: assert property (p_ext_conn) else $error("external entry address wrong");

    property p_int_conn;
        @(posedge mclk) disable iff (!rst_n)
        (res_valid && res.chan <= 16'h001F) |-> res.conn_addr == int_ct_q + {10'h000, res.chan, 6'h00};
    endproperty
    a_int_conn: assert property (p_int_conn) else $error("internal entry address wrong");

    property p_rx_sel;
        @(posedge mclk) disable iff (!rst_n)
        $fell(rx_enable_n) |-> $stable(phy_select_lines) && $past(lk_q) == ahm_pkg::LK_RX_SEL;
    endproperty
    a_rx_sel: assert property (p_rx_sel) else $error("receive enable before select");

    property p_tx_sel;
        @(posedge mclk) disable iff (!rst_n)
        $fell(tx_enable_n) |-> $stable(phy_select_lines) && (!mphy || phy_select_lines == tx_phy_q);
    endproperty
    a_tx_sel: assert property (p_tx_sel) else $error("transmit enable before select");

    property p_cam_phy;
        @(posedge mclk) disable iff (!rst_n)
        (mem.req && mphy && (st_q == ahm_pkg::ST_CAM_WR || st_q == ahm_pkg::ST_CAM_RD))
            |-> mem.addr[3:0] == {2'b00, phy_q};
    endproperty
    a_cam_phy: assert property (p_cam_phy) else $error("PHY missing on address");

endmodule : ahm_map

`default_nettype wire

// ===== bench/ahm_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ahm_mem_model (
    input wire logic mclk, // Clock
    input wire ahm_pkg::ahm_mem_t mem, // Bus request
    output logic mem_ack, // Done pulse
    output logic [31:0] mem_rdata // Read data
);
    logic [31:0] word_q [0:255];
    int wait_q = 0;
    initial begin
        mem_ack = 1'b0;
        mem_rdata = 32'h0000_5a5a;
    end
    // Answer fast or slow by address; data lines churn outside the ack
    always @(posedge mclk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem.req && !mem_ack) begin
            wait_q <= wait_q + 1;
            if (wait_q >= (mem.addr[2] ? 3 : 0)) begin
                wait_q <= 0;
                mem_ack <= 1'b1;
                mem_rdata <= mem.we ? ~mem_rdata : word_q[mem.addr[9:2]];
            end
        end
    end
endmodule : ahm_mem_model
`default_nettype wire

// ===== bench/tb_ahm_map.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ahm_map;
    logic mclk, rst_n, reg_we, reg_re, hdr_valid, hdr_ready, res_valid, mem_ack;
    logic rx_av, tx_av, tx_req, tx_done, rxe_n, txe_n;
    logic [15:0] tx_chan;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, hdr_word, mem_rdata, v, h;
    logic [1:0] phy_req, sel, want_sel;
    ahm_pkg::ahm_result_t res, ex_q[$];
    ahm_pkg::ahm_mem_t mem;
    int n_mismatch = 0, n_compared = 0, cyc = 0;
    integer seed = 32'h609b_7c4a;
    ahm_map dut (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
        .hdr_valid, .hdr_word, .hdr_ready, .res, .res_valid, .mem, .mem_ack, .mem_rdata,
        .phy_request_lines(phy_req), .rx_cell_avail(rx_av), .tx_cell_avail(tx_av),
        .phy_select_lines(sel), .rx_enable_n(rxe_n), .tx_enable_n(txe_n), .tx_req,
        .tx_chan, .tx_done);
    ahm_mem_model mm (.mclk, .mem, .mem_ack, .mem_rdata);
    task check(input logic [50:0] seen, want);
        n_compared++;
        if (seen !== want) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : check
    task conclude;
        if (n_mismatch == 0 && n_compared > 0 && ex_q.size() == 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    // Lets every noted result come out before settings move
    task settle;
        while (ex_q.size() != 0) @(posedge mclk);
    endtask : settle
    task wr(input logic [7:0] a, input logic [31:0] d);
        settle();
        @(posedge mclk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_we <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_re <= 1'b0;
        @(negedge mclk);
        check(reg_rdata, d);
    endtask : rd
    task send(input logic [31:0] hw, input ahm_pkg::ahm_result_t e);
        do @(negedge mclk); while (hdr_ready !== 1'b1);
        check(sel, want_sel);
        check(rxe_n, 1'b0);
        ex_q.push_back(e);
        @(posedge mclk);
        hdr_valid <= 1'b1;
        hdr_word <= hw;
        @(posedge mclk);
        hdr_valid <= 1'b0;
    endtask : send
    // Start-up: reset, then one mapping method and its tables
    task boot(input logic [31:0] c, input logic [1:0] p);
        settle();
        rst_n <= 1'b0;
        phy_req <= p;
        want_sel = c[2] ? p : 2'b00;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        wr(8'h00, c);
        wr(8'h04, 32'h0010_0008);
        wr(8'h08, 32'h0000_0040);
        wr(8'h0c, 32'h0000_0100);
        wr(8'h18, 32'h0000_0800);
        wr(8'h1c, 32'h0000_4000);
        wr(8'h14, 32'h0000_03c0);
        wr(8'h10, 32'hffff_fff0);
    endtask : boot
    // Lookup memory write carries the masked header at the lookup address
    always @(negedge mclk) begin
        if (mem.req === 1'b1 && mem.we === 1'b1) begin
            check(mem.wdata, hdr_word & 32'hffff_fff0);
            check(mem.addr, 32'h0000_03c0 | want_sel);
        end
    end
    // Clock
    always #2.5 mclk = ~mclk;
    // Cut a hang short
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            conclude();
        end
    end
    // Match each result pulse against the oldest note
    always @(negedge mclk) begin
        if (res_valid === 1'b1) begin
            if (ex_q.size() == 0) begin
                n_mismatch++;
                $display("wrong value at %0t: result with no note", $time);
            end else check(res, ex_q.pop_front());
        end
    end
    // Tables, set-up, then mapped, raw and lookup-memory cells
    initial begin
        mclk = 0;
        {rst_n, reg_we, reg_re, hdr_valid, reg_addr, reg_wdata, hdr_word, phy_req} = '0;
        {tx_av, tx_req, tx_done, tx_chan} = '0;
        rx_av = 1'b1;
        for (int i = 0; i < 256; i++) mm.word_q[i] = 0;
        mm.word_q[8'h12] = 32'h0003_0100;
        mm.word_q[8'h11] = 32'h0003_0100;
        mm.word_q[8'h19] = 32'h0003_0200;
        mm.word_q[8'h81] = 32'h0028_0000;
        mm.word_q[8'hc1] = 32'h0029_0000;
        mm.word_q[8'hf0] = 32'h0000_0021;
        boot(32'h0000_0003, 2'b00);
        rd(8'h08, 32'h0000_0040);
        rd(8'hfc, 32'h0000_0000);
        for (int k = 0; k < 4; k++) begin
            v = $random(seed);
            h = {12'h001, v[13:0], 2'b10, 4'h0};
            send(h, '{1'b0, 2'b00, 16'h0028, 32'h0000_4a00});
            send(h ^ 32'h0010_0000, '{1'b1, 2'b00, 16'h0000, 32'h0000_0800});
        end
        wr(8'h04, 32'h0010_0009);
        send(h | 32'h0000_0040, '{1'b1, 2'b00, 16'h0000, 32'h0000_0800});
        send(h & 32'hfff0_003f, '{1'b0, 2'b00, 16'h0028, 32'h0000_4a00});
        wr(8'h04, 32'h0010_0000);
        send(h | 32'h0000_0008, '{1'b1, 2'b00, 16'h0000, 32'h0000_0800});
        send(h, '{1'b0, 2'b00, 16'h0028, 32'h0000_4a00});
        boot(32'h0000_0037, 2'b01);
        send(h, '{1'b0, 2'b01, 16'h0029, 32'h0000_4a40});
        rd(8'h30, 32'h0020_0020);
        rd(8'h34, 32'h0000_0010);
        boot(32'h0000_0001, 2'b00);
        send(h, '{1'b0, 2'b00, 16'h0021, 32'h0000_4840});
        boot(32'h0000_0035, 2'b01);
        send(h, '{1'b0, 2'b01, 16'h0021, 32'h0000_4840});
        settle();
        mm.word_q[8'hf0] = 32'h8000_0021;
        send(h, '{1'b1, 2'b00, 16'h0000, 32'h0000_0800});
        // Transmit with receive held off: select comes from the queue entry
        rx_av <= 1'b0;
        boot(32'h0000_0035, 2'b01);
        tx_chan <= 16'h0022;
        tx_req <= 1'b1;
        tx_av <= 1'b1;
        @(posedge mclk);
        tx_req <= 1'b0;
        do @(negedge mclk); while (txe_n !== 1'b0);
        check(sel, 2'b10);
        @(posedge mclk);
        tx_done <= 1'b1;
        @(posedge mclk);
        tx_done <= 1'b0;
        @(negedge mclk);
        check(txe_n, 1'b1);
        repeat (20) @(posedge mclk);
        conclude();
    end
endmodule : tb_ahm_map
`default_nettype wire
